// file: pkg/wlse_pkg.sv
// Constants, types and carriers shared by the wide load, stack and ALU slice.
package wlse_pkg;
  // ---------------------------------------------------------------
  // T-state totals per instruction form
  // ---------------------------------------------------------------
  localparam logic [4:0] T_ALU = 5'h04;
  localparam logic [4:0] T_LDI = 5'h0a;
  localparam logic [4:0] T_DIR_SHORT = 5'h10;
  localparam logic [4:0] T_DIR_LONG = 5'h14;
  localparam logic [4:0] T_PUSH = 5'h0b;
  localparam logic [4:0] T_PUSH_IDX = 5'h0f;
  localparam logic [4:0] T_POP = 5'h0a;
  localparam logic [4:0] T_POP_IDX = 5'h0e;
  localparam logic [4:0] T_PFX_NOP = 5'h06;
  // ---------------------------------------------------------------
  // Opcodes and prefixes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PFX_EXT = 8'hed;
  localparam logic [7:0] OP_PFX_IDX0 = 8'hdd;
  localparam logic [7:0] OP_PFX_IDX1 = 8'hfd;
  localparam logic [7:0] OP_ST_DIR = 8'h22;
  localparam logic [7:0] OP_LOAD_DIR = 8'h2a;
  localparam logic [7:0] OP_PUSH_IDX = 8'he5;
  localparam logic [7:0] OP_POP_IDX = 8'he1;
  localparam int IDX_CHOICE_POS = 5;
  // ---------------------------------------------------------------
  // Flag bit positions
  // ---------------------------------------------------------------
  localparam int FL_S = 7;
  localparam int FL_Z = 6;
  localparam int FL_H = 4;
  localparam int FL_PV = 2;
  localparam int FL_N = 1;
  localparam int FL_C = 0;
  // ---------------------------------------------------------------
  // Pair codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] PAIR_FIRST = 3'h0;
  localparam logic [2:0] PAIR_SECOND = 3'h1;
  localparam logic [2:0] PAIR_PTR = 3'h2;
  localparam logic [2:0] PAIR_STK = 3'h3;
  localparam logic [2:0] PAIR_ACCF = 3'h4;
  localparam logic [2:0] PAIR_IDX0 = 3'h5;
  localparam logic [2:0] PAIR_IDX1 = 3'h6;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ---------------------------------------------------------------
  // APB register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PC = 8'h04;
  localparam logic [7:0] ADDR_ACCF = 8'h08;
  localparam logic [7:0] ADDR_GEN = 8'h0c;
  localparam logic [7:0] ADDR_PTRSP = 8'h10;
  localparam logic [7:0] ADDR_IDX = 8'h14;

  typedef enum logic [2:0] {
    S_FETCH, S_DECODE, S_IMM_RD, S_IMM_GET,
    S_DAT_RD, S_DAT_GET, S_DAT_WR, S_WAIT
  } wlse_state_type;

  typedef enum logic [2:0] {
    K_NONE, K_LDI, K_ST, K_LDM, K_PUSH, K_POP
  } wlse_kind_type;

  typedef enum logic [1:0] {PFX_NONE, PFX_EXT, PFX_IDX} wlse_pfx_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } wlse_mem_req_type;
endpackage

// file: logic/wlse_exec.sv
// Decode and execute slice: wide loads, stack traffic and register ALU ops.
//
// Overview of operation
// - Pair immediate load fills the chosen pair in 10 T states, flags kept.
// - Each 16-bit operand or direct address is fetched low byte first.
// - Direct pair store puts low at nn, high at nn+1, in 16 or 20 T.
// - Direct pair load takes low from nn, high from nn+1, in 16 or 20 T.
// - Both encodings of the pointer pair direct load give the same result.
// - Push puts high at stack-1, low at stack-2, stack less 2; 11 or 15 T.
// - Pop takes low at stack, high at stack+1, stack plus 2; 10 or 14 T.
// - Add puts A plus r in A in 4 T with S, Z, H, V, C set and N cleared.
// - Add with carry also adds the carry flag, flags exactly as add.
// - Subtract takes r from A in 4 T with borrow flags and N set.
// - Subtract with borrow also takes the carry, flags as subtract.
// - AND sets S, Z, parity from the result, sets H, clears N and C.
// - OR sets S, Z, parity from the result and clears H, N and C.
// - The register field decodes 000 to B through L in order, 111 to A.
// - Pair field: first, second, pointer, stack; 11 is A, F for the stack.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module wlse_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output wlse_pkg::wlse_mem_req_type mem_req,
  input wire logic [7:0] mem_rdata
);
  import wlse_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  wlse_state_type state_r;
  wlse_kind_type kind_r;
  wlse_pfx_type pfx_r;
  logic [4:0] t_cnt_r, tot_r;
  logic [2:0] sel_r;
  logic ixc_r, hi_r, run_r;
  logic [15:0] ea_r, pc_r, stk_ptr_r, idx0_r, idx1_r;
  logic [7:0] imm_r, a_r, f_r, b_r, c_r, d_r, e_r, h_r, l_r;

  // Pair view by code; the pair field decodes here.
  function automatic logic [15:0] pair_get(input logic [2:0] s);
    case (s)
      PAIR_FIRST: pair_get = {b_r, c_r};
      PAIR_SECOND: pair_get = {d_r, e_r};
      PAIR_PTR: pair_get = {h_r, l_r};
      PAIR_STK: pair_get = stk_ptr_r;
      PAIR_ACCF: pair_get = {a_r, f_r};
      PAIR_IDX0: pair_get = idx0_r;
      PAIR_IDX1: pair_get = idx1_r;
      default: pair_get = RST_WORD;
    endcase
  endfunction

  // Eight-bit operand by register field; 110 is memory and never used.
  function automatic logic [7:0] reg_get(input logic [2:0] r);
    case (r)
      3'h0: reg_get = b_r;
      3'h1: reg_get = c_r;
      3'h2: reg_get = d_r;
      3'h3: reg_get = e_r;
      3'h4: reg_get = h_r;
      3'h5: reg_get = l_r;
      3'h7: reg_get = a_r;
      default: reg_get = RST_BYTE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  // The opcode is read straight off the bus in the decode cycle.
  wire [7:0] op = mem_rdata;
  wire [1:0] pair_select_field = op[5:4];
  wire pn = (pfx_r == PFX_NONE);
  wire px = (pfx_r == PFX_EXT);
  wire pi = (pfx_r == PFX_IDX);
  wire pfx_take = pn && (op == OP_PFX_EXT || op == OP_PFX_IDX0 ||
                         op == OP_PFX_IDX1);
  wire dec_go = (state_r == S_DECODE) && !pfx_take;
  wire d_ldi = pn && op[7:6] == 2'b00 && op[3:0] == 4'h1;
  wire d_st = (pn && op == OP_ST_DIR) || (pi && op == OP_ST_DIR) ||
              (px && op[7:6] == 2'b01 && op[3:0] == 4'h3);
  // Both encodings of the pointer pair load land on the same path.
  wire d_ldm = (pn && op == OP_LOAD_DIR) || (pi && op == OP_LOAD_DIR) ||
               (px && op[7:6] == 2'b01 && op[3:0] == 4'hb);
  wire d_push = (pn && op[7:6] == 2'b11 && op[3:0] == 4'h5) ||
                (pi && op == OP_PUSH_IDX);
  wire d_pop = (pn && op[7:6] == 2'b11 && op[3:0] == 4'h1) ||
               (pi && op == OP_POP_IDX);
  // XOR and compare (101, 111) and the memory operand are left out.
  wire d_alu = pn && op[7:6] == 2'b10 && op[5:3] != 3'b101 &&
               op[5:3] != 3'b111 && op[2:0] != 3'b110;
  wire alu_go = dec_go && d_alu;
  wire [2:0] idx_sel = ixc_r ? PAIR_IDX1 : PAIR_IDX0;
  wire [2:0] stk_sel = (pair_select_field == 2'b11) ? PAIR_ACCF :
                       {1'b0, pair_select_field};
  wire ptr_op = pn && (op == OP_ST_DIR || op == OP_LOAD_DIR);
  wire [2:0] dec_sel = pi ? idx_sel : (d_push || d_pop) ? stk_sel :
                       ptr_op ? PAIR_PTR : {1'b0, pair_select_field};
  wlse_kind_type dec_kind;
  logic [4:0] dec_tot;
  wlse_state_type dec_next;

  // Kind, T-state total and first step of the decoded instruction.
  always_comb begin
    dec_kind = K_NONE;
    // A prefix already used two cycles, so its no-op total is longer.
    dec_tot = pn ? T_ALU : T_PFX_NOP;
    dec_next = S_WAIT;
    if (d_ldi) begin
      dec_kind = K_LDI;
      dec_tot = T_LDI;
      dec_next = S_IMM_RD;
    end else if (d_st || d_ldm) begin
      dec_kind = d_st ? K_ST : K_LDM;
      dec_tot = ptr_op ? T_DIR_SHORT : T_DIR_LONG;
      dec_next = S_IMM_RD;
    end else if (d_push) begin
      dec_kind = K_PUSH;
      dec_tot = pi ? T_PUSH_IDX : T_PUSH;
      dec_next = S_DAT_WR;
    end else if (d_pop) begin
      dec_kind = K_POP;
      dec_tot = pi ? T_POP_IDX : T_POP;
      dec_next = S_DAT_RD;
    end
  end

  // ---------------------------------------------------------------
  // ALU
  // ---------------------------------------------------------------
  // Carry in only for the with-carry forms, which have bit 3 set.
  wire [7:0] src8 = reg_get(op[2:0]);
  wire cin = op[3] & f_r[FL_C];
  wire [8:0] sum9 = {1'b0, a_r} + {1'b0, src8} + {8'h00, cin};
  wire [8:0] dif9 = {1'b0, a_r} - {1'b0, src8} - {8'h00, cin};
  wire [4:0] hsum = {1'b0, a_r[3:0]} + {1'b0, src8[3:0]} + {4'h0, cin};
  wire [4:0] hdif = {1'b0, a_r[3:0]} - {1'b0, src8[3:0]} - {4'h0, cin};
  wire is_sub = (op[5:4] == 2'b01);
  wire is_log = op[5];
  wire [7:0] log8 = op[4] ? (a_r | src8) : (a_r & src8);
  wire [7:0] res8 = is_log ? log8 : is_sub ? dif9[7:0] : sum9[7:0];
  wire ovf_add = (a_r[7] == src8[7]) && (sum9[7] != a_r[7]);
  wire ovf_sub = (a_r[7] != src8[7]) && (dif9[7] != a_r[7]);
  wire fh = is_log ? !op[4] : is_sub ? hdif[4] : hsum[4];
  wire fpv = is_log ? ~^res8 : is_sub ? ovf_sub : ovf_add;
  wire fc = is_log ? 1'b0 : is_sub ? dif9[8] : sum9[8];
  wire [7:0] f_alu = {res8[7], res8 == 8'h00, f_r[5], fh,
                      f_r[3], fpv, is_sub, fc};

  // ---------------------------------------------------------------
  // Pair write and stack step
  // ---------------------------------------------------------------
  wire pw_en = hi_r && ((state_r == S_IMM_GET && kind_r == K_LDI) ||
                        state_r == S_DAT_GET);
  wire [15:0] pw_val = {op, imm_r};
  wire [15:0] sel_val = pair_get(sel_r);
  wire last_wr = hi_r ? (kind_r == K_ST) : (kind_r == K_PUSH);
  wire stk_dn = state_r == S_DAT_WR && kind_r == K_PUSH && !hi_r;
  wire stk_up = state_r == S_DAT_GET && kind_r == K_POP && hi_r;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite;
  wire hit = paddr inside {ADDR_CTRL, ADDR_PC, ADDR_ACCF, ADDR_GEN,
                           ADDR_PTRSP, ADDR_IDX};
  wire [31:0] rd_val =
    (paddr == ADDR_CTRL) ? {30'h0, state_r != S_FETCH, run_r} :
    (paddr == ADDR_PC) ? {16'h0000, pc_r} :
    (paddr == ADDR_ACCF) ? {16'h0000, a_r, f_r} :
    (paddr == ADDR_GEN) ? {b_r, c_r, d_r, e_r} :
    (paddr == ADDR_PTRSP) ? {h_r, l_r, stk_ptr_r} :
    (paddr == ADDR_IDX) ? {idx0_r, idx1_r} : 32'h0;

  // Answer is staged in setup so that every access takes one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      run_r <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !hit;
      prdata <= apb_setup && !pwrite ? rd_val : 32'h0;
      if (apb_wr && paddr == ADDR_CTRL) begin
        run_r <= pwdata[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and memory bus
  // ---------------------------------------------------------------
  // Memory reads are taken in the cycle after the request, so the
  // memory must answer combinationally while rd is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_FETCH;
      kind_r <= K_NONE;
      pfx_r <= PFX_NONE;
      t_cnt_r <= 5'h00;
      tot_r <= T_ALU;
      sel_r <= PAIR_FIRST;
      ixc_r <= 1'b0;
      hi_r <= 1'b0;
      ea_r <= RST_WORD;
      imm_r <= RST_BYTE;
      pc_r <= RST_WORD;
      mem_req <= '0;
    end else begin
      mem_req.rd <= 1'b0;
      mem_req.wr <= 1'b0;
      t_cnt_r <= t_cnt_r + 5'h01;
      case (state_r)
        S_FETCH: begin
          if (run_r || !pn) begin
            mem_req.addr <= pc_r;
            mem_req.rd <= 1'b1;
            pc_r <= pc_r + 16'h0001;
            state_r <= S_DECODE;
          end else begin
            t_cnt_r <= 5'h00;
          end
        end
        S_DECODE: begin
          if (pfx_take) begin
            pfx_r <= (op == OP_PFX_EXT) ? PFX_EXT : PFX_IDX;
            ixc_r <= op[IDX_CHOICE_POS];
            state_r <= S_FETCH;
          end else begin
            pfx_r <= PFX_NONE;
            kind_r <= dec_kind;
            tot_r <= dec_tot;
            sel_r <= dec_sel;
            hi_r <= d_push;
            ea_r <= d_push ? stk_ptr_r - 16'h0001 : stk_ptr_r;
            state_r <= dec_next;
          end
        end
        S_IMM_RD: begin
          mem_req.addr <= pc_r;
          mem_req.rd <= 1'b1;
          pc_r <= pc_r + 16'h0001;
          state_r <= S_IMM_GET;
        end
        S_IMM_GET: begin
          hi_r <= !hi_r;
          if (!hi_r) begin
            imm_r <= op;
            state_r <= S_IMM_RD;
          end else begin
            ea_r <= {op, imm_r};
            state_r <= (kind_r == K_LDI) ? S_WAIT :
                       (kind_r == K_ST) ? S_DAT_WR : S_DAT_RD;
          end
        end
        S_DAT_RD: begin
          mem_req.addr <= ea_r;
          mem_req.rd <= 1'b1;
          state_r <= S_DAT_GET;
        end
        S_DAT_GET: begin
          hi_r <= !hi_r;
          if (!hi_r) begin
            imm_r <= op;
            ea_r <= ea_r + 16'h0001;
            state_r <= S_DAT_RD;
          end else begin
            state_r <= S_WAIT;
          end
        end
        S_DAT_WR: begin
          mem_req.addr <= ea_r;
          mem_req.wdata <= hi_r ? sel_val[15:8] : sel_val[7:0];
          mem_req.wr <= 1'b1;
          if (last_wr) begin
            state_r <= S_WAIT;
          end else begin
            hi_r <= !hi_r;
            ea_r <= (kind_r == K_PUSH) ? ea_r - 16'h0001 :
                    ea_r + 16'h0001;
          end
        end
        S_WAIT: begin
          if (t_cnt_r == tot_r - 5'h01) begin
            t_cnt_r <= 5'h00;
            state_r <= S_FETCH;
          end
        end
        default: state_r <= S_FETCH;
      endcase
      if (apb_wr && paddr == ADDR_PC && !run_r) begin
        pc_r <= pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Wide transfers leave the flags alone unless the pair is A with F.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {a_r, f_r, b_r, c_r} <= {RST_WORD, RST_WORD};
      {d_r, e_r, h_r, l_r} <= {RST_WORD, RST_WORD};
      {stk_ptr_r, idx0_r, idx1_r} <= {RST_WORD, RST_WORD, RST_WORD};
    end else begin
      if (alu_go) begin
        a_r <= res8;
        f_r <= f_alu;
      end
      if (pw_en) begin
        case (sel_r)
          PAIR_FIRST: {b_r, c_r} <= pw_val;
          PAIR_SECOND: {d_r, e_r} <= pw_val;
          PAIR_PTR: {h_r, l_r} <= pw_val;
          PAIR_STK: stk_ptr_r <= pw_val;
          PAIR_ACCF: {a_r, f_r} <= pw_val;
          PAIR_IDX0: idx0_r <= pw_val;
          PAIR_IDX1: idx1_r <= pw_val;
          default: ;
        endcase
      end
      if (stk_dn) stk_ptr_r <= stk_ptr_r - 16'h0002;
      if (stk_up) stk_ptr_r <= stk_ptr_r + 16'h0002;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_push_bytes;
    mem_req.wr && mem_req.addr == $past(stk_ptr_r, 2) - 16'h0001 ##1
    mem_req.wr && mem_req.addr == $past(stk_ptr_r, 3) - 16'h0002 &&
    stk_ptr_r == $past(stk_ptr_r, 3) - 16'h0002;
  endsequence
  sequence s_pop_bytes;
    mem_req.rd && mem_req.addr == $past(stk_ptr_r, 2) ##2
    mem_req.rd && mem_req.addr == $past(stk_ptr_r, 4) + 16'h0001;
  endsequence

  property p_wait_exit;
    state_r == S_WAIT && t_cnt_r == tot_r - 5'h01 |=>
      state_r == S_FETCH && t_cnt_r == 5'h00;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("bad exit");
  property p_alu_len;
    alu_go |-> ##3 state_r == S_FETCH;
  endproperty
  a_alu_len: assert property (p_alu_len) else $error("alu length");
  property p_ldi_len;
    dec_go && d_ldi |-> ##9 state_r == S_FETCH;
  endproperty
  a_ldi_len: assert property (p_ldi_len) else $error("load length");
  property p_add;
    alu_go && op[5:3] == 3'b000 |=>
      a_r == $past(a_r) + $past(src8) && !f_r[FL_N];
  endproperty
  a_add: assert property (p_add) else $error("add result");
  property p_adc;
    alu_go && op[5:3] == 3'b001 |=>
      a_r == $past(a_r) + $past(src8) + {7'h00, $past(f_r[FL_C])};
  endproperty
  a_adc: assert property (p_adc) else $error("adc result");
  property p_sub;
    alu_go && op[5:3] == 3'b010 |=>
      a_r == $past(a_r) - $past(src8) && f_r[FL_N] &&
      f_r[FL_C] == ($past(src8) > $past(a_r));
  endproperty
  a_sub: assert property (p_sub) else $error("sub result");
  property p_subb;
    alu_go && op[5:3] == 3'b011 |=> f_r[FL_N] &&
      a_r == $past(a_r) - $past(src8) - {7'h00, $past(f_r[FL_C])};
  endproperty
  a_subb: assert property (p_subb) else $error("borrow result");
  property p_and;
    alu_go && op[5:3] == 3'b100 |=> f_r[FL_H] && !f_r[FL_C] &&
      a_r == ($past(a_r) & $past(src8)) && f_r[FL_PV] == ~^a_r;
  endproperty
  a_and: assert property (p_and) else $error("and result");
  property p_or;
    alu_go && op[5:3] == 3'b110 |=> !f_r[FL_H] && !f_r[FL_C] &&
      a_r == ($past(a_r) | $past(src8));
  endproperty
  a_or: assert property (p_or) else $error("or result");
  property p_zero;
    alu_go |=> f_r[FL_Z] == (a_r == 8'h00) && f_r[FL_S] == a_r[7];
  endproperty
  a_zero: assert property (p_zero) else $error("sign or zero");
  property p_imm;
    state_r == S_IMM_GET && !hi_r |->
      ##2 mem_req.addr == $past(mem_req.addr, 2) + 16'h0001;
  endproperty
  a_imm: assert property (p_imm) else $error("operand order");
  property p_push;
    dec_go && dec_kind == K_PUSH |-> ##2 s_push_bytes;
  endproperty
  a_push: assert property (p_push) else $error("push order");
  property p_pop;
    dec_go && dec_kind == K_POP |->
      ##2 s_pop_bytes ##1 stk_ptr_r == $past(stk_ptr_r, 5) + 16'h0002;
  endproperty
  a_pop: assert property (p_pop) else $error("pop order");
endmodule

// file: dv/wlse_mem_model.sv
// Behavioural system memory on the far side of the slice's memory bus.
`timescale 1ns/1ps
module wlse_mem_model (
  input wire logic pclk,
  input wire wlse_pkg::wlse_mem_req_type mem_req,
  output logic [7:0] mem_rdata
);
  import wlse_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  int rd_cyc [0:255];
  int cyc;
  // Outside a read the bus shows the inverse of the last byte, so a
  // late sample by the device cannot pass by luck.
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_r;
  // The whole space starts as no-ops so a runaway fetch stays harmless.
  initial begin
    cyc = 0;
    last_r = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Writes land at the edge ending the write cycle; the cycle of each
  // low-page read is kept so the bench can time the instructions.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd) begin
      last_r <= mem_rdata;
      if (mem_req.addr < 16'h0100) rd_cyc[mem_req.addr[7:0]] <= cyc;
    end
  end
endmodule

// file: dv/wide_load_stack_alu_exec_tb.sv
// Self-checking bench for the wide load, stack and ALU slice.
`timescale 1ns/1ps
module wide_load_stack_alu_exec_tb;
  import wlse_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, mem_rdata;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  wlse_mem_req_type mem_req;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  logic [15:0] lf = 16'hae1a;
  logic [32:0] exp_q[$];
  logic [7:0] prog [0:40] = '{8'h01, 8'h34, 8'h12, 8'h31, 8'h00, 8'h80,
    8'hc5, 8'hd1, 8'hf1, 8'h80, 8'h89, 8'h92, 8'h9b, 8'ha2, 8'hb3,
    8'h21, 8'hcd, 8'hab, 8'h22, 8'h00, 8'h90, 8'hed, 8'h4b, 8'h00,
    8'h90, 8'h2a, 8'h00, 8'h90, 8'hfd, 8'h2a, 8'h00, 8'h90, 8'hdd,
    8'he5, 8'hdd, 8'he1, 8'hed, 8'h43, 8'h00, 8'ha0, 8'h00};
  int oa [0:19] = '{0, 3, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 18, 21, 25,
    28, 32, 34, 36, 40};
  int tt [0:18] = '{10, 10, 11, 10, 10, 4, 4, 4, 4, 4, 4, 10, 16, 20, 16,
    20, 15, 14, 20};
  logic [7:0] a, f;
  logic [15:0] af;
  wlse_exec i_wlse_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rdata(mem_rdata));
  wlse_mem_model i_wlse_mem_model (.pclk(pclk), .mem_req(mem_req),
    .mem_rdata(mem_rdata));
  always #20 pclk = ~pclk;
  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Reference ALU for the six register operations on the accumulator.
  function automatic logic [15:0] alu(input int op, input logic [7:0] x,
      input logic [7:0] r, input logic [7:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic ci, v;
    ci = (op == 1 || op == 3) ? fl[0] : 1'b0;
    s = (op < 2) ? {1'b0, x} + r + ci : {1'b0, x} - r - ci;
    h = (op < 2) ? {1'b0, x[3:0]} + r[3:0] + ci : {1'b0, x[3:0]} - r[3:0] - ci;
    v = (op < 2) ? (x[7] == r[7]) && (s[7] != x[7])
                 : (x[7] != r[7]) && (s[7] != x[7]);
    if (op > 3) begin
      s = {1'b0, (op == 4) ? (x & r) : (x | r)};
      h = {op == 4, 4'h0};
      v = ~^s[7:0];
    end
    return {s[7:0], s[7], s[7:0] == 8'h00, fl[5], h[4], fl[3], v,
      op == 2 || op == 3, op < 4 && s[8]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // One APB transfer; a read notes its expected {pslverr, prdata}.
  task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude();
    $display("compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Read monitor: each completed read is matched to the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check(33'h1, 33'h0);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // A hang ends the run as a failure.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    lf = nxt(lf);
    f = lf[7:0];
    a = lf[15:8];
    for (int i = 0; i < 41; i++) i_wlse_mem_model.mem[i] = prog[i];
    i_wlse_mem_model.mem[16'h8000] = f;
    i_wlse_mem_model.mem[16'h8001] = a;
    apb(1, ADDR_PC, 32'h0, 33'h0);
    apb(1, ADDR_CTRL, 32'h1, 33'h0);
    while (i_wlse_mem_model.rd_cyc[40] == 0) @(posedge pclk);
    apb(1, ADDR_CTRL, 32'h0, 33'h0);
    repeat (10) @(posedge pclk);
    $display("program run done");
    for (int i = 0; i < 19; i++)
      check(33'(i_wlse_mem_model.rd_cyc[oa[i+1]] -
        i_wlse_mem_model.rd_cyc[oa[i]]), 33'(tt[i]));
    af = {a, f};
    for (int i = 0; i < 6; i++)
      af = alu(i, af[15:8], i[0] ? 8'h34 : 8'h12, af[7:0]);
    lf = nxt(lf);
    apb(1, ADDR_ACCF, {lf, lf}, 33'h0);
    apb(0, ADDR_ACCF, 32'h0, {17'h0, af});
    apb(0, ADDR_GEN, 32'h0, {1'b0, 32'habcd1234});
    apb(0, ADDR_PTRSP, 32'h0, {1'b0, 32'habcd8002});
    // The second index is loaded and the first is pushed and popped as
    // zero, so a swapped index choice shows up in this word.
    apb(0, ADDR_IDX, 32'h0, {1'b0, 32'h0000abcd});
    apb(0, 8'h40, 32'h0, {1'b1, 32'h0});
    apb(0, ADDR_CTRL, 32'h0, 33'h0);
    repeat (3) @(posedge pclk);
    $display("register readback done");
    check({25'h0, i_wlse_mem_model.mem[16'h7fff]}, 33'h12);
    check({25'h0, i_wlse_mem_model.mem[16'h7ffe]}, 33'h34);
    check({25'h0, i_wlse_mem_model.mem[16'h9000]}, 33'hcd);
    check({25'h0, i_wlse_mem_model.mem[16'h9001]}, 33'hab);
    check({25'h0, i_wlse_mem_model.mem[16'ha000]}, 33'hcd);
    check({25'h0, i_wlse_mem_model.mem[16'ha001]}, 33'hab);
    check({25'h0, i_wlse_mem_model.mem[16'h8001]}, 33'h00);
    check({25'h0, i_wlse_mem_model.mem[16'h8000]}, 33'h00);
    $display("memory image done");
    conclude();
  end
endmodule
